// ===== pkg/mhs_pkg.sv
// Purpose: shared constants, types and states of the homing and axis status block
// Assumes: 40 MHz clock, word-aligned classic Wishbone slave, byte address = 4 * index
// Notes: mode field carries the base mode in the low bits plus two modifier bits
package mhs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned POWER_TICK_MS = 10;
  localparam int unsigned POWER_TICK_CYCLES = CLK_HZ / 1000 * POWER_TICK_MS;

  // register indexes
  localparam logic [7:0] IDX_HOMING_MODE = 8'hc1;
  localparam logic [7:0] IDX_COARSE_SPEED = 8'hc2;
  localparam logic [7:0] IDX_FINE_SPEED = 8'hc3;
  localparam logic [7:0] IDX_SWITCH_SPAN = 8'hc4;
  localparam logic [7:0] IDX_PRE_ZERO_POS = 8'hc5;
  localparam logic [7:0] IDX_RAMP_CURRENT = 8'hc8;
  localparam logic [7:0] IDX_POWER_CUT_DELAY = 8'hcc;
  localparam logic [7:0] IDX_LOAD_READING = 8'hce;
  localparam logic [7:0] IDX_FAULT_FLAGS = 8'hcf;
  localparam logic [7:0] IDX_CONTROL = 8'hd0;
  localparam logic [7:0] IDX_RUN_SPEED = 8'hd1;
  localparam logic [7:0] IDX_RUN_CURRENT = 8'hd2;
  localparam logic [7:0] IDX_STALL_SPEED = 8'hd3;
  localparam logic [7:0] IDX_MAX_DEVIATION = 8'hd4;
  localparam logic [7:0] IDX_STATUS = 8'hd5;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd6;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd7;
  localparam logic [7:0] IDX_POSITION = 8'hd8;

  // homing mode field
  localparam int MODE_RIGHT_BIT = 6;
  localparam int MODE_INVERT_BIT = 7;
  localparam logic [5:0] MODE_LEFT_ONLY = 6'h01;
  localparam logic [5:0] MODE_RIGHT_LEFT = 6'h02;
  localparam logic [5:0] MODE_RIGHT_LEFT_BOTH = 6'h03;
  localparam logic [5:0] MODE_LEFT_BOTH = 6'h04;
  localparam logic [5:0] MODE_HOME_NEG_REV = 6'h05;
  localparam logic [5:0] MODE_HOME_POS_REV = 6'h06;
  localparam logic [5:0] MODE_HOME_POS = 6'h07;
  localparam logic [5:0] MODE_HOME_NEG = 6'h08;

  // control, fault and interrupt bits
  localparam int CTRL_HOME_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_DIR_BIT = 3;
  localparam int FAULT_STALL_BIT = 0;
  localparam int FAULT_DEV_BIT = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_STALL_BIT = 1;
  localparam int IRQ_DEV_BIT = 2;

  // reset values
  localparam logic [7:0] RST_HOMING_MODE = 8'h01;
  localparam logic [15:0] RST_POWER_CUT_DELAY = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic home;
    logic right;
    logic left;
  } mhs_sw_s;

  typedef struct packed {
    logic run;
    logic dir;
    logic [31:0] speed;
  } mhs_motion_s;

  typedef enum logic [2:0] {HS_IDLE, HS_PRE, HS_COARSE, HS_BACK, HS_APPROACH, HS_ZERO} mhs_home_e;
endpackage : mhs_pkg

// ===== verilog/mhs_power_cut.sv
// Purpose: standstill timer that removes motor power after a delay in 10 ms units
// Assumes: standstill comes from logic on clk
// Notes: a delay of zero keeps power on for ever
`timescale 1ns/100ps
module mhs_power_cut #(
  parameter int unsigned TICK_CYCLES = mhs_pkg::POWER_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic standstill,
  input wire logic [15:0] delay,
  output logic powerOn
);
  logic [31:0] tickCnt_reg;
  logic [15:0] unitCnt_reg;
  logic powerOn_reg;
  wire tickDone = tickCnt_reg == 32'(TICK_CYCLES - 1);
  wire expired = unitCnt_reg >= delay;

  always_ff @(posedge clk) begin
    if (rst || !standstill || delay == 16'h0000) begin
      tickCnt_reg <= 32'h0000_0000;
      unitCnt_reg <= 16'h0000;
      powerOn_reg <= 1'b1;
    end else if (expired) begin
      powerOn_reg <= 1'b0;
    end else if (tickDone) begin
      tickCnt_reg <= 32'h0000_0000;
      unitCnt_reg <= unitCnt_reg + 16'h0001;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
    end
  end

  assign powerOn = powerOn_reg;
endmodule : mhs_power_cut

// ===== verilog/mhs_homing_top.sv
// Purpose: homing sequencer, fault stops, current select and status registers of one axis
// Assumes: classic Wishbone slave, switch pins asynchronous, motion inputs on clk
// Notes: writes take effect on the edge where ack is high
// Functional notes
// - modes 1-4: left only; right then left; right then left both sides; left both
// - mode 5 seeks home negative, reverses at left; mode 6 positive, reverses at right
// - modes 7 and 8 seek home positive and negative, ignoring end switches
// - adding 128 inverts home switch polarity in home-switch modes
// - adding 64 uses the right reference switch instead of left in stop-switch modes
// - rough travel toward the reference uses the coarse speed
// - switching point is approached at the separately set fine speed
// - after modes 2 or 3 the end switch distance is readable
// - position is zeroed during homing; prior value captured first
// - boost current drives ramps; zero boost means normal run current
// - power is cut after freewheeling delay in 10 ms units at standstill
// - freewheeling delay zero, the default, never cuts power
// - load measurement readable, up to 1023
// - fault flags: stall is 1, deviation is 2, both may be set
// - fault flags clear on read and when a motion command executes
// - above stall speed, load reaching zero stops the motor
// - deviation above maximum stops the motor; maximum zero disables
`timescale 1ns/100ps
module mhs_homing_top #(
  parameter int unsigned TICK_CYCLES = mhs_pkg::POWER_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire mhs_pkg::mhs_sw_s swPins,
  input wire logic stepPulse,
  input wire logic rampActive,
  input wire logic [31:0] actualSpeed,
  input wire logic [31:0] encoderPos,
  input wire logic [9:0] loadValue,
  output mhs_pkg::mhs_motion_s motionOut,
  output logic [7:0] currentCmd,
  output logic powerOn,
  output logic homeBusy,
  output logic irq
);
  function automatic logic [31:0] absDiff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return d[31] ? (32'h0000_0000 - d) : d;
  endfunction : absDiff

  mhs_pkg::mhs_sw_s swMeta_reg;
  mhs_pkg::mhs_sw_s swSync_reg;
  mhs_pkg::mhs_home_e homeState_reg;
  logic [7:0] homingMode_reg;
  logic [31:0] coarseSpeed_reg;
  logic [31:0] fineSpeed_reg;
  logic [31:0] switchSpan_reg;
  logic [31:0] preZeroPos_reg;
  logic [31:0] preMark_reg;
  logic [31:0] position_reg;
  logic [7:0] rampCurrent_reg;
  logic [7:0] runCurrent_reg;
  logic [15:0] powerCutDelay_reg;
  logic [31:0] runSpeed_reg;
  logic [31:0] stallSpeed_reg;
  logic [31:0] maxDeviation_reg;
  logic [1:0] faultFlags_reg;
  logic [1:0] faultFlags_next;
  logic [mhs_pkg::IRQ_W-1:0] irqStatus_reg;
  logic [mhs_pkg::IRQ_W-1:0] irqStatus_next;
  logic [mhs_pkg::IRQ_W-1:0] irqMask_reg;
  logic runFlag_reg;
  logic runDir_reg;
  logic homeDir_reg;
  logic ack_reg;
  logic [31:0] rdData_reg;

  // bus decode
  wire [7:0] regIdx = adr_i[9:2];
  wire busReq = cyc_i && stb_i;
  wire accept = busReq && ack_reg;
  wire wrAcc = accept && we_i;
  wire rdAcc = accept && !we_i;
  wire [31:0] selMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  logic [31:0] rdMux;
  wire [31:0] wrData = (rdMux & ~selMask) | (dat_i & selMask);
  wire [31:0] laneData = dat_i & selMask;
  wire wrMode = wrAcc && regIdx == mhs_pkg::IDX_HOMING_MODE;
  wire wrCtrl = wrAcc && regIdx == mhs_pkg::IDX_CONTROL;
  wire rdFault = rdAcc && regIdx == mhs_pkg::IDX_FAULT_FLAGS;

  // switches pass two flops before use
  wire leftSw = swSync_reg.left;
  wire rightSw = swSync_reg.right;

  // mode decode
  wire [5:0] modeBase = homingMode_reg[5:0];
  wire isStopMode = modeBase >= mhs_pkg::MODE_LEFT_ONLY && modeBase <= mhs_pkg::MODE_LEFT_BOTH;
  wire isHomeMode = modeBase >= mhs_pkg::MODE_HOME_NEG_REV && modeBase <= mhs_pkg::MODE_HOME_NEG;
  wire useRight = homingMode_reg[mhs_pkg::MODE_RIGHT_BIT] && isStopMode;
  wire invHome = homingMode_reg[mhs_pkg::MODE_INVERT_BIT] && isHomeMode;
  wire homeSw = swSync_reg.home ^ invHome;
  wire refSw = useRight ? rightSw : leftSw;
  wire preSw = useRight ? leftSw : rightSw;
  wire refDir = useRight;
  wire hasPre = modeBase == mhs_pkg::MODE_RIGHT_LEFT || modeBase == mhs_pkg::MODE_RIGHT_LEFT_BOTH;
  wire bothSides = modeBase == mhs_pkg::MODE_RIGHT_LEFT_BOTH || modeBase == mhs_pkg::MODE_LEFT_BOTH;
  wire targetSw = isHomeMode ? homeSw : refSw;
  wire startDir = isHomeMode ? (modeBase == mhs_pkg::MODE_HOME_POS_REV || modeBase == mhs_pkg::MODE_HOME_POS)
                             : (hasPre ? !refDir : refDir);
  wire revAtLeft = modeBase == mhs_pkg::MODE_HOME_NEG_REV && leftSw && !homeDir_reg;
  wire revAtRight = modeBase == mhs_pkg::MODE_HOME_POS_REV && rightSw && homeDir_reg;
  wire homingMoving = homeState_reg != mhs_pkg::HS_IDLE && homeState_reg != mhs_pkg::HS_ZERO;
  wire fineLeg = homeState_reg == mhs_pkg::HS_BACK || homeState_reg == mhs_pkg::HS_APPROACH;

  // commands
  wire busyNow = homeState_reg != mhs_pkg::HS_IDLE;
  wire cmdStop = wrCtrl && dat_i[mhs_pkg::CTRL_STOP_BIT];
  wire cmdHome = wrCtrl && dat_i[mhs_pkg::CTRL_HOME_BIT] && !busyNow && !cmdStop;
  wire cmdRun = wrCtrl && dat_i[mhs_pkg::CTRL_RUN_BIT] && !busyNow && !cmdStop;
  wire motionCmd = cmdStop || cmdHome || cmdRun;

  // fault stops
  wire stallStop = motionOut.run && actualSpeed > stallSpeed_reg && loadValue == 10'h000;
  wire posDev = absDiff(position_reg, encoderPos) > maxDeviation_reg;
  wire devStop = motionOut.run && maxDeviation_reg != 32'h0000_0000 && posDev;
  wire anyStop = stallStop || devStop || cmdStop;
  wire zeroNow = homeState_reg == mhs_pkg::HS_ZERO;

  always_comb begin
    unique case (regIdx)
      mhs_pkg::IDX_HOMING_MODE: rdMux = {24'h00_0000, homingMode_reg};
      mhs_pkg::IDX_COARSE_SPEED: rdMux = coarseSpeed_reg;
      mhs_pkg::IDX_FINE_SPEED: rdMux = fineSpeed_reg;
      mhs_pkg::IDX_SWITCH_SPAN: rdMux = switchSpan_reg;
      mhs_pkg::IDX_PRE_ZERO_POS: rdMux = preZeroPos_reg;
      mhs_pkg::IDX_RAMP_CURRENT: rdMux = {24'h00_0000, rampCurrent_reg};
      mhs_pkg::IDX_POWER_CUT_DELAY: rdMux = {16'h0000, powerCutDelay_reg};
      mhs_pkg::IDX_LOAD_READING: rdMux = {22'h00_0000, loadValue};
      mhs_pkg::IDX_FAULT_FLAGS: rdMux = {30'h0000_0000, faultFlags_reg};
      mhs_pkg::IDX_CONTROL: rdMux = {28'h000_0000, runDir_reg, 3'h0};
      mhs_pkg::IDX_RUN_SPEED: rdMux = runSpeed_reg;
      mhs_pkg::IDX_RUN_CURRENT: rdMux = {24'h00_0000, runCurrent_reg};
      mhs_pkg::IDX_STALL_SPEED: rdMux = stallSpeed_reg;
      mhs_pkg::IDX_MAX_DEVIATION: rdMux = maxDeviation_reg;
      mhs_pkg::IDX_STATUS: rdMux = {26'h000_0000, homeState_reg, powerOn, busyNow, runFlag_reg};
      mhs_pkg::IDX_IRQ_STATUS: rdMux = {29'h0000_0000, irqStatus_reg};
      mhs_pkg::IDX_IRQ_MASK: rdMux = {29'h0000_0000, irqMask_reg};
      mhs_pkg::IDX_POSITION: rdMux = position_reg;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // sticky flags: a set in the same cycle as a clear wins
  wire [1:0] faultSet = {devStop, stallStop};
  wire faultClr = rdFault || motionCmd;
  assign faultFlags_next = (faultFlags_reg & ~{2{faultClr}}) | faultSet;
  wire [mhs_pkg::IRQ_W-1:0] irqSet = {devStop, stallStop, zeroNow};
  wire irqWr = wrAcc && regIdx == mhs_pkg::IDX_IRQ_STATUS;
  wire [mhs_pkg::IRQ_W-1:0] irqClr = irqWr ? laneData[mhs_pkg::IRQ_W-1:0] : '0;
  assign irqStatus_next = (irqStatus_reg & ~irqClr) | irqSet;

  always_ff @(posedge clk) begin
    swMeta_reg <= swPins;
    swSync_reg <= swMeta_reg;
  end

  // bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdData_reg <= mhs_pkg::RST_WORD;
    end else begin
      ack_reg <= busReq && !ack_reg;
      rdData_reg <= rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      homingMode_reg <= mhs_pkg::RST_HOMING_MODE;
      coarseSpeed_reg <= mhs_pkg::RST_WORD;
      fineSpeed_reg <= mhs_pkg::RST_WORD;
      rampCurrent_reg <= 8'h00;
      runCurrent_reg <= 8'h00;
      powerCutDelay_reg <= mhs_pkg::RST_POWER_CUT_DELAY;
      runSpeed_reg <= mhs_pkg::RST_WORD;
      stallSpeed_reg <= mhs_pkg::RST_WORD;
      maxDeviation_reg <= mhs_pkg::RST_WORD;
      irqMask_reg <= '0;
    end else if (wrAcc) begin
      if (wrMode) homingMode_reg <= wrData[7:0];
      if (regIdx == mhs_pkg::IDX_COARSE_SPEED) coarseSpeed_reg <= wrData;
      if (regIdx == mhs_pkg::IDX_FINE_SPEED) fineSpeed_reg <= wrData;
      if (regIdx == mhs_pkg::IDX_RAMP_CURRENT) rampCurrent_reg <= wrData[7:0];
      if (regIdx == mhs_pkg::IDX_RUN_CURRENT) runCurrent_reg <= wrData[7:0];
      if (regIdx == mhs_pkg::IDX_POWER_CUT_DELAY) powerCutDelay_reg <= wrData[15:0];
      if (regIdx == mhs_pkg::IDX_RUN_SPEED) runSpeed_reg <= wrData;
      if (regIdx == mhs_pkg::IDX_STALL_SPEED) stallSpeed_reg <= wrData;
      if (regIdx == mhs_pkg::IDX_MAX_DEVIATION) maxDeviation_reg <= wrData;
      if (regIdx == mhs_pkg::IDX_IRQ_MASK) irqMask_reg <= wrData[mhs_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      faultFlags_reg <= 2'b00;
      irqStatus_reg <= '0;
      runFlag_reg <= 1'b0;
      runDir_reg <= 1'b0;
    end else begin
      faultFlags_reg <= faultFlags_next;
      irqStatus_reg <= irqStatus_next;
      if (anyStop || cmdHome) begin
        runFlag_reg <= 1'b0;
      end else if (cmdRun) begin
        runFlag_reg <= 1'b1;
        runDir_reg <= dat_i[mhs_pkg::CTRL_DIR_BIT];
      end
    end
  end

  // position counter; zeroing wins over a step in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      position_reg <= mhs_pkg::RST_WORD;
    end else if (zeroNow) begin
      position_reg <= mhs_pkg::RST_WORD;
    end else if (stepPulse) begin
      position_reg <= motionOut.dir ? position_reg + 32'h0000_0001 : position_reg - 32'h0000_0001;
    end
  end

  // homing sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      homeState_reg <= mhs_pkg::HS_IDLE;
      homeDir_reg <= 1'b0;
      preMark_reg <= mhs_pkg::RST_WORD;
      preZeroPos_reg <= mhs_pkg::RST_WORD;
      switchSpan_reg <= mhs_pkg::RST_WORD;
    end else if ((stallStop || devStop || cmdStop) && !zeroNow) begin
      // the zero cycle always finishes, else the counter is cleared with its old value lost
      homeState_reg <= mhs_pkg::HS_IDLE;
    end else begin
      unique case (homeState_reg)
        mhs_pkg::HS_IDLE: begin
          if (cmdHome) begin
            homeDir_reg <= startDir;
            if (hasPre) homeState_reg <= mhs_pkg::HS_PRE;
            else if (isStopMode || isHomeMode) homeState_reg <= mhs_pkg::HS_COARSE;
            else homeState_reg <= mhs_pkg::HS_ZERO;
          end
        end
        mhs_pkg::HS_PRE: begin
          if (preSw) begin
            preMark_reg <= position_reg;
            homeDir_reg <= refDir;
            homeState_reg <= mhs_pkg::HS_COARSE;
          end
        end
        mhs_pkg::HS_COARSE: begin
          if (targetSw) begin
            homeDir_reg <= !homeDir_reg;
            homeState_reg <= mhs_pkg::HS_BACK;
          end else if (revAtLeft || revAtRight) begin
            homeDir_reg <= !homeDir_reg;
          end
        end
        mhs_pkg::HS_BACK: begin
          if (!targetSw) begin
            if (bothSides) begin
              homeDir_reg <= !homeDir_reg;
              homeState_reg <= mhs_pkg::HS_APPROACH;
            end else begin
              homeState_reg <= mhs_pkg::HS_ZERO;
            end
          end
        end
        mhs_pkg::HS_APPROACH: begin
          if (targetSw) homeState_reg <= mhs_pkg::HS_ZERO;
        end
        mhs_pkg::HS_ZERO: begin
          preZeroPos_reg <= position_reg;
          if (hasPre) switchSpan_reg <= absDiff(preMark_reg, position_reg);
          homeState_reg <= mhs_pkg::HS_IDLE;
        end
      endcase
    end
  end

  mhs_power_cut #(
    .TICK_CYCLES(TICK_CYCLES)
  ) powerCut (
    .clk(clk),
    .rst(rst),
    .standstill(actualSpeed == 32'h0000_0000 && !motionOut.run),
    .delay(powerCutDelay_reg),
    .powerOn(powerOn)
  );

  // motion select: coarse speed on the search legs, fine on the switch legs
  assign motionOut.run = homingMoving || (!busyNow && runFlag_reg);
  assign motionOut.dir = busyNow ? homeDir_reg : runDir_reg;
  assign motionOut.speed = !busyNow ? runSpeed_reg : (fineLeg ? fineSpeed_reg : coarseSpeed_reg);
  assign currentCmd = (rampActive && rampCurrent_reg != 8'h00) ? rampCurrent_reg : runCurrent_reg;
  assign homeBusy = busyNow;
  assign irq = |(irqStatus_reg & irqMask_reg);
  assign ack_o = ack_reg;
  assign dat_o = rdData_reg;

  a_ramp_boost: assert property (@(posedge clk) disable iff (rst)
    (rampActive && rampCurrent_reg != 8'h00) |-> currentCmd == rampCurrent_reg)
    else $error("boost current not driven during ramp");
  a_boost_zero_run: assert property (@(posedge clk) disable iff (rst)
    (rampCurrent_reg == 8'h00 || !rampActive) |-> currentCmd == runCurrent_reg)
    else $error("run current not used");
  a_stall_stop: assert property (@(posedge clk) disable iff (rst)
    stallStop |=> !motionOut.run && faultFlags_reg[mhs_pkg::FAULT_STALL_BIT])
    else $error("stall did not stop motor and flag");
  a_dev_stop: assert property (@(posedge clk) disable iff (rst)
    devStop |=> !motionOut.run && faultFlags_reg[mhs_pkg::FAULT_DEV_BIT])
    else $error("deviation did not stop motor and flag");
  a_dev_disabled: assert property (@(posedge clk) disable iff (rst)
    maxDeviation_reg == 32'h0000_0000 |-> !devStop)
    else $error("deviation check active at zero maximum");
  a_fault_read_clear: assert property (@(posedge clk) disable iff (rst)
    (rdFault && !stallStop && !devStop) |=> faultFlags_reg == 2'b00)
    else $error("fault flags not cleared on read");
  a_zero_capture: assert property (@(posedge clk) disable iff (rst)
    zeroNow |=> preZeroPos_reg == $past(position_reg) && homeState_reg == mhs_pkg::HS_IDLE && !motionOut.run)
    else $error("pre-zero position not captured");
  a_busy_no_run: assert property (@(posedge clk) disable iff (rst)
    (busyNow && wrCtrl && dat_i[mhs_pkg::CTRL_RUN_BIT]) |=> !runFlag_reg)
    else $error("run accepted during homing");
  a_coarse_speed: assert property (@(posedge clk) disable iff (rst)
    (homeState_reg == mhs_pkg::HS_PRE || homeState_reg == mhs_pkg::HS_COARSE) |-> motionOut.speed == coarseSpeed_reg)
    else $error("coarse speed not used");
  a_fine_speed: assert property (@(posedge clk) disable iff (rst)
    fineLeg |-> motionOut.speed == fineSpeed_reg && motionOut.run)
    else $error("fine speed not used");
  a_home_pos_dir: assert property (@(posedge clk) disable iff (rst)
    (homeState_reg == mhs_pkg::HS_COARSE && modeBase == mhs_pkg::MODE_HOME_POS) |-> motionOut.dir)
    else $error("mode 7 not moving positive");
  a_rev_at_left: assert property (@(posedge clk) disable iff (rst)
    (homeState_reg == mhs_pkg::HS_COARSE && revAtLeft && !targetSw && !anyStop) |=> homeDir_reg)
    else $error("no reversal at left switch");
  a_home_invert: assert property (@(posedge clk) disable iff (rst)
    (homeState_reg == mhs_pkg::HS_COARSE && invHome && !swSync_reg.home && !anyStop)
    |=> homeState_reg == mhs_pkg::HS_BACK)
    else $error("inverted home switch not taken as found");
  a_power_kept: assert property (@(posedge clk) disable iff (rst)
    (powerCutDelay_reg == 16'h0000 && $past(powerCutDelay_reg) == 16'h0000) |-> powerOn)
    else $error("power cut with zero delay");
endmodule : mhs_homing_top

// ===== tb/mhs_motor_model.sv
// Purpose: motor and switch model, one step per cycle while run is high
// Assumes: left switch below -20, right switch above 20, all pins active high
// Notes: home pin repeats every 16 steps so a search in either direction finds it
`timescale 1ns/100ps
module mhs_motor_model (
  input wire logic clk,
  input wire logic rst,
  input wire mhs_pkg::mhs_motion_s mo,
  output mhs_pkg::mhs_sw_s sw,
  output logic step,
  output logic [31:0] spd,
  output logic signed [31:0] pos
);
  // combinational step so no pulse trails the cycle where run falls
  assign step = mo.run;
  assign spd = mo.run ? mo.speed : 32'h0000_0000;
  assign sw.left = pos < -20;
  assign sw.right = pos > 20;
  assign sw.home = pos[3:0] < 4'h3;
  always_ff @(posedge clk) begin
    if (rst) pos <= 32'h0000_0000;
    else if (step) pos <= mo.dir ? pos + 1 : pos - 1;
  end
endmodule : mhs_motor_model

// ===== tb/tb_mhs_homing_top.sv
// Purpose: register level tests of homing, fault stops, current select and power cut
// Assumes: motor model steps once per cycle; TICK_CYCLES cut to 4
// Notes: pre-zero expectations come from the model position
`timescale 1ns/100ps
module tb_mhs_homing_top;
  logic clk, rst, cyc, stb, we, ack, step, rampA, pwr, busy, irq, got1, sawF, fDir, clrF;
  logic [3:0] sel;
  logic [11:0] adr;
  logic [31:0] dat, dout, q, aspd, enc, fSpd;
  logic [9:0] load;
  logic [7:0] cur;
  logic signed [31:0] pos, base = 32'sh0000_0000;
  mhs_pkg::mhs_sw_s sw;
  mhs_pkg::mhs_motion_s mo;
  int miscompares = 0;
  int checks = 0;
  int i, n;
  logic [7:0] md [10] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h04, 8'h07, 8'h08, 8'h05, 8'h41, 8'h85};
  logic [9:0] dr = 10'h12e;
  mhs_homing_top #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(dat), .dat_o(dout), .ack_o(ack), .swPins(sw), .stepPulse(step),
    .rampActive(rampA), .actualSpeed(aspd), .encoderPos(enc), .loadValue(load), .motionOut(mo),
    .currentCmd(cur), .powerOn(pwr), .homeBusy(busy), .irq(irq));
  mhs_motor_model motor (.clk(clk), .rst(rst), .mo(mo), .sw(sw), .step(step), .spd(aspd), .pos(pos));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2_000_000;
    miscompares++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chkr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask : chkr
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, a, 2'b00};
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rchk
  task automatic waitc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : waitc
  // first moving cycle of a search and whether the fine speed ever shows
  always @(posedge clk) begin
    if (clrF === 1'b1) begin
      {got1, sawF} <= 2'b00;
    end else if (busy === 1'b1 && mo.run === 1'b1) begin
      if (!got1) {got1, fDir, fSpd} <= {1'b1, mo.dir, mo.speed};
      if (mo.speed === 32'h0000_0005) sawF <= 1'b1;
    end
  end
  initial begin
    {rst, cyc, stb, we, sel, adr, dat, rampA, enc, load} = {1'b1, 3'b000, 4'h0, 12'h000, 32'h0, 1'b0, 32'h0, 10'h3ff};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(mhs_pkg::IDX_HOMING_MODE, 32'h0000_0001);
    rchk(mhs_pkg::IDX_POWER_CUT_DELAY, 32'h0000_0000);
    rchk(8'he0, 32'h0000_0000);
    wr(mhs_pkg::IDX_LOAD_READING, 32'h0000_0000);
    rchk(mhs_pkg::IDX_LOAD_READING, 32'h0000_03ff);
    wr(mhs_pkg::IDX_COARSE_SPEED, 32'h0000_0032);
    wr(mhs_pkg::IDX_FINE_SPEED, 32'h0000_0005);
    for (i = 0; i < 10; i++) begin
      clrF <= 1'b1;
      wr(mhs_pkg::IDX_HOMING_MODE, {24'h00_0000, md[i]});
      clrF <= 1'b0;
      wr(mhs_pkg::IDX_CONTROL, 32'h0000_0001);
      waitc(3);
      for (n = 0; n < 3000 && busy !== 1'b0; n++) waitc(1);
      chk(32'(mo.run), 32'h0000_0000);
      chk(32'(fDir), 32'(dr[i]));
      chk(fSpd, 32'h0000_0032);
      chk(32'(sawF), 32'h0000_0001);
      rchk(mhs_pkg::IDX_POSITION, 32'h0000_0000);
      // the counter restarts at zero after each search, the model does not
      rchk(mhs_pkg::IDX_PRE_ZERO_POS, pos - base);
      base = pos;
      bus(1'b0, mhs_pkg::IDX_SWITCH_SPAN, 32'h0000_0000);
      if (i == 1 || i == 2) chkr(q, 32'h0000_0024, 32'h0000_0038);
      rchk(mhs_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
      wr(mhs_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    end
    wr(mhs_pkg::IDX_RUN_SPEED, 32'h0000_0064);
    wr(mhs_pkg::IDX_STALL_SPEED, 32'h0000_0005);
    wr(mhs_pkg::IDX_IRQ_MASK, 32'h0000_0002);
    wr(mhs_pkg::IDX_CONTROL, 32'h0000_000a);
    load <= 10'h000;
    waitc(4);
    chk(32'(mo.run), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    rchk(mhs_pkg::IDX_FAULT_FLAGS, 32'h0000_0001);
    rchk(mhs_pkg::IDX_FAULT_FLAGS, 32'h0000_0000);
    wr(mhs_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
    waitc(1);
    chk(32'(irq), 32'h0000_0000);
    wr(mhs_pkg::IDX_STALL_SPEED, 32'h0000_00c8);
    wr(mhs_pkg::IDX_CONTROL, 32'h0000_000a);
    waitc(4);
    chk(32'(mo.run), 32'h0000_0001);
    @(posedge clk);
    load <= 10'h3ff;
    wr(mhs_pkg::IDX_MAX_DEVIATION, 32'h0000_0001);
    waitc(4);
    chk(32'(mo.run), 32'h0000_0000);
    rchk(mhs_pkg::IDX_IRQ_STATUS, 32'h0000_0004);
    wr(mhs_pkg::IDX_MAX_DEVIATION, 32'h0000_0000);
    wr(mhs_pkg::IDX_CONTROL, 32'h0000_000a);
    waitc(4);
    chk(32'(mo.run), 32'h0000_0001);
    rchk(mhs_pkg::IDX_FAULT_FLAGS, 32'h0000_0000);
    wr(mhs_pkg::IDX_MAX_DEVIATION, 32'h0000_0001);
    waitc(4);
    rchk(mhs_pkg::IDX_FAULT_FLAGS, 32'h0000_0002);
    wr(mhs_pkg::IDX_RAMP_CURRENT, 32'h0000_0040);
    wr(mhs_pkg::IDX_RUN_CURRENT, 32'h0000_0020);
    rampA <= 1'b1;
    waitc(1);
    chk(32'(cur), 32'h0000_0040);
    wr(mhs_pkg::IDX_RAMP_CURRENT, 32'h0000_0000);
    waitc(1);
    chk(32'(cur), 32'h0000_0020);
    waitc(40);
    chk(32'(pwr), 32'h0000_0001);
    wr(mhs_pkg::IDX_POWER_CUT_DELAY, 32'h0000_0003);
    wr(mhs_pkg::IDX_MAX_DEVIATION, 32'h0000_0000);
    wr(mhs_pkg::IDX_CONTROL, 32'h0000_000a);
    wr(mhs_pkg::IDX_CONTROL, 32'h0000_0004);
    waitc(4);
    chk(32'(pwr), 32'h0000_0001);
    waitc(16);
    chk(32'(pwr), 32'h0000_0000);
    report_and_stop();
  end
endmodule : tb_mhs_homing_top
